/* logic/pieb2_pkg.sv */
/*
 * package for the second peripheral interrupt enable bank: register
 * indices, field positions, reset values, bus answers and carrier types.
 * assumes a 32-bit avalon-mm slave with byte addresses (index * 4).
 */
package pieb2_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;

  // register indices; byte address is index * 4
  localparam logic [7:0] IDX_FLAGS_ONE = 8'h0C;
  localparam logic [7:0] IDX_FLAGS_TWO = 8'h0D;
  localparam logic [7:0] IDX_ENABLES_TWO = 8'h8D;
  localparam logic [7:0] IDX_FLAGS_CLEAR = 8'h90;

  // field positions, shared by flags and masks
  localparam int BIT_CAPCOMP_TWO = 0;
  localparam int BIT_COLLISION = 3;
  localparam int BIT_EEPROM_DONE = 4;
  localparam int BIT_RESERVED = 6;

  // bits that store a value; 7, 5, 2, 1 read zero
  localparam logic [REG_W-1:0] STORE_MASK = 8'h59;
  localparam logic [REG_W-1:0] ENABLES_RESET = 8'h00;
  localparam logic [REG_W-1:0] FLAGS_RESET = 8'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic eeprom_write_done;
    logic collision;
    logic capcomp_two;
  } pieb2_event_type;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [3:0] byteenable;
    logic [DATA_W-1:0] writedata;
  } pieb2_req_type;

endpackage

/* logic/pieb2_top.sv */
/*
 * second peripheral interrupt enable bank with its companion flag
 * register and a one-line level interrupt request, behind avalon-mm.
 * assumes event strobes come from logic on mclk_i, one cycle each.
 */
`timescale 1ns/10ps

module pieb2_top
  import pieb2_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // avalon-mm slave
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [ADDR_W-1:0] address_i,
  input wire logic [3:0] byteenable_i,
  input wire logic [DATA_W-1:0] writedata_i,
  output logic [DATA_W-1:0] readdata_o,
  output logic waitrequest_o,
  output logic [1:0] response_o,
  // peripheral events, one-cycle pulses
  input wire pieb2_event_type events_i,
  // interrupt request
  output logic irq_o
);

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  pieb2_req_type req;
  logic ack_q;
  // waitrequest has its own flop so the pin never sees an inverter glitch
  logic wait_q;
  logic take_wr;
  logic take;
  logic lane0;
  logic [REG_W-1:0] enables_q;
  logic [REG_W-1:0] enables_d;
  logic [REG_W-1:0] flags_q;
  logic [REG_W-1:0] flags_d;
  logic [REG_W-1:0] ev_vec;
  logic [DATA_W-1:0] readdata_q;
  logic [1:0] response_q;
  logic irq_q;
  logic mapped;

  assign req = '{read: read_i, write: write_i, address: address_i,
                 byteenable: byteenable_i, writedata: writedata_i};

  // the access completes at the edge where ack_q is high
  assign take = (req.read | req.write) & ack_q;
  assign take_wr = req.write & ack_q;
  assign lane0 = req.byteenable[0];

  assign mapped = hit(req.address, IDX_FLAGS_TWO)
                | hit(req.address, IDX_ENABLES_TWO)
                | hit(req.address, IDX_FLAGS_CLEAR);

  // one wait state: decode settles before the answer is given
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_q <= 1'b0;
      wait_q <= 1'b1;
    end else begin
      ack_q <= (req.read | req.write) & ~ack_q;
      wait_q <= ~((req.read | req.write) & ~ack_q);
    end
  end

  always_comb begin
    ev_vec = '0;
    ev_vec[BIT_CAPCOMP_TWO] = events_i.capcomp_two;
    ev_vec[BIT_COLLISION] = events_i.collision;
    ev_vec[BIT_EEPROM_DONE] = events_i.eeprom_write_done;
  end

  always_comb begin
    enables_d = enables_q;
    if (take_wr && lane0 && hit(req.address, IDX_ENABLES_TWO)) begin
      enables_d = req.writedata[REG_W-1:0] & STORE_MASK;
    end
  end

  always_comb begin
    flags_d = flags_q;
    if (take_wr && lane0 && hit(req.address, IDX_FLAGS_TWO)) begin
      flags_d = req.writedata[REG_W-1:0] & STORE_MASK;
    end
    if (take_wr && lane0 && hit(req.address, IDX_FLAGS_CLEAR)) begin
      flags_d = flags_d & ~req.writedata[REG_W-1:0];
    end
    // an event in the clearing cycle still lands, mask or not
    flags_d = flags_d | ev_vec;
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      enables_q <= ENABLES_RESET;
    end else begin
      enables_q <= enables_d;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flags_q <= FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // masks gate only the request line; reserved bit 6 never requests
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (flags_d[BIT_CAPCOMP_TWO] & enables_d[BIT_CAPCOMP_TWO])
             | (flags_d[BIT_COLLISION] & enables_d[BIT_COLLISION])
             | (flags_d[BIT_EEPROM_DONE] & enables_d[BIT_EEPROM_DONE]);
    end
  end

  // read data captured at the first request edge, while ack_q is low; clear register reads zero
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      readdata_q <= '0;
      response_q <= RESP_OKAY;
    end else if ((req.read | req.write) && !ack_q) begin
      readdata_q <= '0;
      response_q <= mapped ? RESP_OKAY : RESP_SLVERR;
      if (req.read && hit(req.address, IDX_ENABLES_TWO)) begin
        readdata_q[REG_W-1:0] <= enables_q & STORE_MASK;
      end
      if (req.read && hit(req.address, IDX_FLAGS_TWO)) begin
        readdata_q[REG_W-1:0] <= flags_q & STORE_MASK;
      end
    end
  end

  assign readdata_o = readdata_q;
  assign waitrequest_o = wait_q;
  assign response_o = response_q;
  assign irq_o = irq_q;

  a_enable_store: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    take_wr && lane0 && hit(req.address, IDX_ENABLES_TWO)
    |=> enables_q == ($past(req.writedata[REG_W-1:0]) & STORE_MASK))
    else $error("enable register write not stored");

  a_capcomp_gate: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    flags_q[BIT_CAPCOMP_TWO] && enables_q[BIT_CAPCOMP_TWO] |-> irq_o)
    else $error("capture/compare request not raised");

  a_collision_gate: assert property (@(posedge mclk_i)
    disable iff (!arst_n_i)
    flags_q[BIT_COLLISION] && enables_q[BIT_COLLISION] |-> irq_o)
    else $error("collision request not raised");

  a_eeprom_gate: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    flags_q[BIT_EEPROM_DONE] && enables_q[BIT_EEPROM_DONE] |-> irq_o)
    else $error("eeprom request not raised");

  a_irq_masked: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    irq_o |-> |(flags_q & enables_q & 8'h19))
    else $error("request raised with no enabled flag");

  a_event_sets: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    events_i.collision |=> flags_q[BIT_COLLISION])
    else $error("collision event lost");

  a_flag_place: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    events_i.eeprom_write_done && !events_i.capcomp_two
    && !hit(req.address, IDX_FLAGS_TWO) && !$past(flags_q[BIT_CAPCOMP_TWO])
    |=> flags_q[BIT_EEPROM_DONE])
    else $error("eeprom flag not at bit 4");

  a_unused_zero: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (enables_q & ~STORE_MASK) == 8'h00
    && (readdata_o[REG_W-1:0] & ~STORE_MASK) == 8'h00)
    else $error("unimplemented bit holds a one");

  a_bus_answer: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    $rose(read_i) && waitrequest_o |=> !waitrequest_o)
    else $error("no answer after one wait state");

  // bus answer: exactly one wait state, then one ready cycle
  a_wait_pair: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (req.read | req.write) && waitrequest_o |=> !waitrequest_o)
    else $error("request not answered after one wait state");

  a_wait_single: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    !waitrequest_o |=> waitrequest_o)
    else $error("ready held longer than one cycle");

  a_wait_idle: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    !(req.read | req.write) && waitrequest_o |=> waitrequest_o)
    else $error("ready given with no request");

  // response code follows the decode of the first request cycle
  a_resp_unmapped: assert property (@(posedge mclk_i)
    disable iff (!arst_n_i)
    (req.read | req.write) && waitrequest_o && !mapped
    |=> response_o == RESP_SLVERR)
    else $error("unmapped access not answered with slave error");

  a_resp_mapped: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (req.read | req.write) && waitrequest_o && mapped
    |=> response_o == RESP_OKAY)
    else $error("mapped access not answered okay");

  // read data: value at the first request edge, upper bits zero
  a_read_enables: assert property (@(posedge mclk_i)
    disable iff (!arst_n_i)
    req.read && waitrequest_o && hit(req.address, IDX_ENABLES_TWO)
    |=> readdata_o[REG_W-1:0] == ($past(enables_q) & STORE_MASK))
    else $error("enable register read wrong");

  a_read_flags: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    req.read && waitrequest_o && hit(req.address, IDX_FLAGS_TWO)
    |=> readdata_o[REG_W-1:0] == ($past(flags_q) & STORE_MASK))
    else $error("flag register read wrong");

  a_read_clear: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    req.read && waitrequest_o && hit(req.address, IDX_FLAGS_CLEAR)
    |=> readdata_o == '0)
    else $error("clear register read not zero");

  a_read_upper: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    readdata_o[DATA_W-1:REG_W] == '0)
    else $error("upper read data bits not zero");

  // enable storage: only a lane 0 write to its own index changes it
  a_enable_hold: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    !(take_wr && lane0 && hit(req.address, IDX_ENABLES_TWO))
    |=> $stable(enables_q))
    else $error("enable register changed without a write");

  a_lane_ignore: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    take_wr && !lane0 |=> $stable(enables_q))
    else $error("write without lane 0 reached enables");

  a_unmapped_nowr: assert property (@(posedge mclk_i)
    disable iff (!arst_n_i)
    take_wr && !mapped |=> $stable(enables_q))
    else $error("unmapped write reached enables");

  // flags: sticky, set by events, written or cleared by software
  a_flags_sticky: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    !take_wr && ev_vec == '0 |=> flags_q == $past(flags_q))
    else $error("flag changed without event or write");

  a_capcomp_sets: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    events_i.capcomp_two |=> flags_q[BIT_CAPCOMP_TWO])
    else $error("capture/compare event lost");

  a_eeprom_sets: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    events_i.eeprom_write_done |=> flags_q[BIT_EEPROM_DONE])
    else $error("eeprom event lost");

  a_flags_write: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    take_wr && lane0 && hit(req.address, IDX_FLAGS_TWO) && ev_vec == '0
    |=> flags_q == ($past(req.writedata[REG_W-1:0]) & STORE_MASK))
    else $error("flag register write not stored");

  a_flags_clear: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    take_wr && lane0 && hit(req.address, IDX_FLAGS_CLEAR) && ev_vec == '0
    |=> (flags_q & $past(req.writedata[REG_W-1:0])) == 8'h00)
    else $error("flag clear left a bit set");

  // set wins over a clear in the same cycle
  a_set_wins: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    take_wr && lane0 && hit(req.address, IDX_FLAGS_CLEAR)
    && events_i.collision |=> flags_q[BIT_COLLISION])
    else $error("clear beat a collision event");

  a_flags_unused: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (flags_q & ~STORE_MASK) == 8'h00)
    else $error("unimplemented flag bit holds a one");

  // reserved bit 6 alone must never raise a request
  a_reserved_quiet: assert property (@(posedge mclk_i)
    disable iff (!arst_n_i)
    (flags_q & enables_q & 8'h19) == 8'h00 |-> !irq_o)
    else $error("reserved bit raised a request");

  a_irq_level: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    irq_o == |(flags_q & enables_q & 8'h19))
    else $error("request line does not follow gated flags");

endmodule

/* verif/pieb2_tb.sv */
/* testbench for the second interrupt enable bank: reset values, storage
   mask, sticky flags, per-source gating, unmapped access.
   assumes pieb2_pkg and pieb2_top from logic/. */
`timescale 1ns/10ps
module testbench;
  import pieb2_pkg::*;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  logic [ADDR_W-1:0] address_i = '0;
  logic [3:0] byteenable_i = 4'hF;
  logic [DATA_W-1:0] writedata_i = '0;
  logic [DATA_W-1:0] readdata_o;
  logic waitrequest_o;
  logic [1:0] response_o;
  pieb2_event_type events_i = '0;
  logic irq_o;
  int fails = 0;
  int tests_run = 0;
  logic [DATA_W-1:0] rd;
  logic [1:0] rsp;
  int pos [3] = '{0, 3, 4};
  // byte addresses: enables, flags, clear
  localparam logic [ADDR_W-1:0] A_EN = 10'h234;
  localparam logic [ADDR_W-1:0] A_FL = 10'h034;
  localparam logic [ADDR_W-1:0] A_CL = 10'h240;

  always #2.5 mclk_i = ~mclk_i;

  pieb2_top uut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .read_i(read_i),
    .write_i(write_i), .address_i(address_i), .byteenable_i(byteenable_i),
    .writedata_i(writedata_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .response_o(response_o),
    .events_i(events_i), .irq_o(irq_o));

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
    end
  endtask

  // holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    read_i <= !wr;
    write_i <= wr;
    address_i <= a;
    writedata_i <= {24'h0, d};
    do begin
      @(posedge mclk_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 20);
    if (n >= 20) begin
      fails++;
      final_report();
    end
    rd = readdata_o;
    rsp = response_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic pulse(input int i);
    events_i <= pieb2_event_type'(3'b001 << i);
    @(posedge mclk_i);
    events_i <= '0;
    @(posedge mclk_i);
  endtask

  task automatic t_reset();
    bus(1'b0, A_EN, 8'h00);
    check("enables", 32'h0, rd);
    bus(1'b0, A_FL, 8'h00);
    check("flags", 32'h0, rd);
    check("irq", 32'h0, irq_o);
  endtask

  task automatic t_store();
    bus(1'b1, A_EN, 8'hFF);
    bus(1'b0, A_EN, 8'h00);
    check("enables", {24'h0, STORE_MASK}, rd);
    check("enables", 32'h59, rd);
    bus(1'b1, A_EN, 8'h00);
    byteenable_i <= 4'hE;
    bus(1'b1, A_EN, 8'h19);
    byteenable_i <= 4'hF;
    bus(1'b0, A_EN, 8'h00);
    check("enables", 32'h0, rd);
  endtask

  task automatic t_flags();
    for (int i = 0; i < 3; i++) pulse(i);
    bus(1'b0, A_FL, 8'h00);
    check("flags", 32'h19, rd);
    check("irq", 32'h0, irq_o);
    bus(1'b1, A_CL, 8'hFF);
    bus(1'b0, A_FL, 8'h00);
    check("flags", 32'h0, rd);
  endtask

  // each mask passes only its own source
  task automatic t_masks();
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, A_EN, 8'h59 & ~(8'h01 << pos[i]));
      pulse(i);
      check("irq", 32'h0, irq_o);
      bus(1'b1, A_EN, 8'h01 << pos[i]);
      check("irq", 32'h1, irq_o);
      bus(1'b1, A_EN, 8'h00);
      check("irq", 32'h0, irq_o);
      bus(1'b1, A_CL, 8'hFF);
    end
  endtask

  task automatic t_unmapped();
    bus(1'b0, 10'h030, 8'h00);
    check("readdata", 32'h0, rd);
    check("response", {30'h0, RESP_SLVERR}, {30'h0, rsp});
  endtask

  initial begin
    repeat (2) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    @(posedge mclk_i);
    t_reset();
    t_store();
    t_flags();
    t_masks();
    t_unmapped();
    final_report();
  end
endmodule
